// ---- hdl/abx_pkg.sv ----
package abx_pkg;
   // Register byte offsets on the Avalon-MM slave
   localparam logic [5:0] REG_CTRL   = 6'h00;   // Bit 0: extended set enable
   localparam logic [5:0] REG_INSTR  = 6'h04;   // Write issues, read returns last
   localparam logic [5:0] REG_WREG   = 6'h08;   // Working register
   localparam logic [5:0] REG_STATUS = 6'h0C;   // Arithmetic flags
   localparam logic [5:0] REG_BANK   = 6'h10;   // Bank select register
   localparam logic [5:0] REG_PC     = 6'h14;   // Program counter
   localparam logic [5:0] REG_INDEX  = 6'h18;   // Base for indexed literal offset
   localparam logic [5:0] REG_MADDR  = 6'h1C;   // Data memory window address
   localparam logic [5:0] REG_MDATA  = 6'h20;   // Data memory window data
   localparam logic [5:0] REG_INFO   = 6'h24;   // Bit 0 busy, bit 1 last instruction was a taken branch

   // Status flag positions
   localparam int FLG_C  = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z  = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N  = 4;

   // Opcode fields
   localparam logic [5:0] OPC_ADD_CARRY = 6'h08;   // Bits 15:10 = 0010 00
   localparam logic [5:0] OPC_AND_FILE  = 6'h05;   // Bits 15:10 = 0001 01
   localparam logic [7:0] OPC_AND_LIT   = 8'h0B;   // Bits 15:8
   localparam logic [7:0] OPC_BR_CARRY  = 8'hE2;   // Bits 15:8
   localparam logic [7:0] IDX_LIMIT     = 8'h5F;   // Indexed mode at or below
   localparam logic [7:0] ACC_SPLIT     = 8'h60;   // Access bank low/high split

   // Reset values and cycle counts
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [4:0]  RST_FLG  = 5'h00;
   localparam logic [1:0]  Q_LAST   = 2'h3;     // Four phases per instruction cycle
   localparam int          PC_STEP  = 2;        // Bytes per instruction word

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_EXEC  = 2'b01,
      ST_FLUSH = 2'b10
   } abx_state_t;

   typedef enum logic [2:0] {
      CL_NONE = 3'b000,
      CL_ADD  = 3'b001,
      CL_ANDF = 3'b010,
      CL_ANDL = 3'b011,
      CL_BRC  = 3'b100
   } abx_cls_t;
endpackage

// ---- hdl/abx_core.sv ----
`timescale 1ns/1ps
`default_nettype none

module abx_core
   import abx_pkg::*;
#(
   parameter int PC_W    = 21,
   parameter int DMEM_AW = 12
) (
   // Clock and reset
   input  wire logic          i_clk_sys,
   input  wire logic          i_resetn,
   // Avalon-MM slave
   input  wire logic [5:0]    i_avs_address,
   input  wire logic          i_avs_read,
   input  wire logic          i_avs_write,
   input  wire logic [31:0]   i_avs_writedata,
   input  wire logic [3:0]    i_avs_byteenable,
   output logic      [31:0]   o_avs_readdata,
   output logic               o_avs_waitrequest,
   // Core state
   output logic               o_busy
);
   localparam int BK_W = DMEM_AW - 8;

   // Elaboration check: the bank field needs at least one bit
   if (DMEM_AW < 9 || DMEM_AW > 12 || PC_W < 10 || PC_W > 32) begin : g_bad_param
      $error("abx_core: unsupported PC_W or DMEM_AW");
   end

   // Byte-enable merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
      end
      return r;
   endfunction

   // Data memory file
   logic [7:0] mem [2**DMEM_AW];

   abx_state_t           state_r, state_nxt;
   logic [1:0]           q_r, q_nxt;
   logic [15:0]          instr_r, instr_nxt;
   logic [DMEM_AW-1:0]   addr_r, addr_nxt;
   logic [7:0]           opnd_r, opnd_nxt;
   logic [7:0]           res_r, res_nxt;
   logic [4:0]           flg_r, flg_nxt;
   logic [7:0]           wreg_r, wreg_nxt;
   logic [4:0]           status_r, status_nxt;
   logic [BK_W-1:0]      bank_select_register_r, bank_select_register_nxt;
   logic [PC_W-1:0]      program_counter_r, program_counter_nxt;
   logic [DMEM_AW-1:0]   index_r, index_nxt;
   logic [DMEM_AW-1:0]   maddr_r, maddr_nxt;
   logic                 ext_r, ext_nxt;
   logic                 taken_r, taken_nxt;
   logic [31:0]          rdata_r, rdata_nxt;
   logic                 rack_r, rack_nxt;
   logic                 mem_we;
   logic [DMEM_AW-1:0]   mem_wa;
   logic [7:0]           mem_wd;
   abx_cls_t             cls;
   logic                 wr_ok;
   logic [8:0]           sum9;
   logic [4:0]           sum_lo;
   logic [PC_W-1:0]      offset2;
   logic [31:0]          cur, mrg;

   // Instruction class from the opcode fields
   always_comb begin
      if (instr_r[15:10] == OPC_ADD_CARRY) cls = CL_ADD;
      else if (instr_r[15:10] == OPC_AND_FILE) cls = CL_ANDF;
      else if (instr_r[15:8] == OPC_AND_LIT) cls = CL_ANDL;
      else if (instr_r[15:8] == OPC_BR_CARRY) cls = CL_BRC;
      else cls = CL_NONE;
   end

   // Arithmetic helpers
   assign sum9    = {1'b0, wreg_r} + {1'b0, opnd_r} + {8'h00, status_r[FLG_C]};
   assign sum_lo  = {1'b0, wreg_r[3:0]} + {1'b0, opnd_r[3:0]} + {4'h0, status_r[FLG_C]};
   assign offset2 = {{(PC_W-9){instr_r[7]}}, instr_r[7:0], 1'b0};

   // Writes stall while an instruction runs, so software never races the core
   assign wr_ok             = i_avs_write && (state_r == ST_IDLE);
   assign o_avs_waitrequest = (i_avs_write && state_r != ST_IDLE) || (i_avs_read && !rack_r);
   assign o_avs_readdata    = rdata_r;
   assign o_busy            = (state_r != ST_IDLE);

   // Current value of the addressed register, for byte merging
   always_comb begin
      cur = 32'h0000_0000;
      if (i_avs_address == REG_CTRL) cur[0] = ext_r;
      else if (i_avs_address == REG_INSTR) cur[15:0] = instr_r;
      else if (i_avs_address == REG_WREG) cur[7:0] = wreg_r;
      else if (i_avs_address == REG_STATUS) cur[4:0] = status_r;
      else if (i_avs_address == REG_BANK) cur[BK_W-1:0] = bank_select_register_r;
      else if (i_avs_address == REG_PC) cur[PC_W-1:0] = program_counter_r;
      else if (i_avs_address == REG_INDEX) cur[DMEM_AW-1:0] = index_r;
      else if (i_avs_address == REG_MADDR) cur[DMEM_AW-1:0] = maddr_r;
      else if (i_avs_address == REG_MDATA) cur[7:0] = mem[maddr_r];
      else if (i_avs_address == REG_INFO) cur[1:0] = {taken_r, o_busy};
      mrg = merge(cur, i_avs_writedata, i_avs_byteenable);
   end

   // Next-state logic: bus side and the four-phase sequencer
   always_comb begin
      state_nxt = state_r;
      q_nxt = q_r;
      instr_nxt = instr_r;
      addr_nxt = addr_r;
      opnd_nxt = opnd_r;
      res_nxt = res_r;
      flg_nxt = flg_r;
      wreg_nxt = wreg_r;
      status_nxt = status_r;
      bank_select_register_nxt = bank_select_register_r;
      program_counter_nxt = program_counter_r;
      index_nxt = index_r;
      maddr_nxt = maddr_r;
      ext_nxt = ext_r;
      taken_nxt = taken_r;
      rack_nxt = i_avs_read && !rack_r;
      rdata_nxt = (i_avs_read && !rack_r) ? cur : rdata_r;
      mem_we = 1'b0;
      mem_wa = maddr_r;
      mem_wd = mrg[7:0];

      // Register writes, only accepted when idle
      if (wr_ok) begin
         if (i_avs_address == REG_CTRL) begin
            ext_nxt = mrg[0];
         end else if (i_avs_address == REG_INSTR) begin
            instr_nxt = mrg[15:0];
            state_nxt = ST_EXEC;
            q_nxt = 2'h0;
         end else if (i_avs_address == REG_WREG) begin
            wreg_nxt = mrg[7:0];
         end else if (i_avs_address == REG_STATUS) begin
            status_nxt = mrg[4:0];
         end else if (i_avs_address == REG_BANK) begin
            bank_select_register_nxt = mrg[BK_W-1:0];
         end else if (i_avs_address == REG_PC) begin
            program_counter_nxt = mrg[PC_W-1:0];
         end else if (i_avs_address == REG_INDEX) begin
            index_nxt = mrg[DMEM_AW-1:0];
         end else if (i_avs_address == REG_MADDR) begin
            maddr_nxt = mrg[DMEM_AW-1:0];
         end else if (i_avs_address == REG_MDATA) begin
            mem_we = 1'b1;
         end
      end

      case (state_r)
         ST_EXEC: begin
            q_nxt = q_r + 2'h1;
            case (q_r)
               // Decode: form the data memory address
               2'h0: begin
                  if (instr_r[8]) begin
                     addr_nxt = {bank_select_register_r, instr_r[7:0]};
                  end else if (ext_r && instr_r[7:0] <= IDX_LIMIT) begin
                     addr_nxt = index_r + {{BK_W{1'b0}}, instr_r[7:0]};
                  end else if (instr_r[7:0] < ACC_SPLIT) begin
                     addr_nxt = {{BK_W{1'b0}}, instr_r[7:0]};
                  end else begin
                     addr_nxt = {{BK_W{1'b1}}, instr_r[7:0]};
                  end
               end
               // Read the file operand or the literal
               2'h1: begin
                  if (cls == CL_ADD || cls == CL_ANDF) opnd_nxt = mem[addr_r];
                  else opnd_nxt = instr_r[7:0];
               end
               // Compute result and candidate flags
               2'h2: begin
                  flg_nxt = status_r;
                  if (cls == CL_ADD) begin
                     res_nxt = sum9[7:0];
                     flg_nxt[FLG_C]  = sum9[8];
                     flg_nxt[FLG_DC] = sum_lo[4];
                     flg_nxt[FLG_OV] = (wreg_r[7] == opnd_r[7]) && (sum9[7] != wreg_r[7]);
                     flg_nxt[FLG_N]  = sum9[7];
                     flg_nxt[FLG_Z]  = (sum9[7:0] == 8'h00);
                  end else begin
                     res_nxt = wreg_r & opnd_r;
                     flg_nxt[FLG_N] = res_nxt[7];
                     flg_nxt[FLG_Z] = (res_nxt == 8'h00);
                  end
               end
               // Write destination and advance the counter
               default: begin
                  state_nxt = ST_IDLE;
                  taken_nxt = 1'b0;
                  program_counter_nxt = program_counter_r + PC_W'(PC_STEP);
                  if (cls == CL_ADD || cls == CL_ANDF || cls == CL_ANDL) begin
                     status_nxt = flg_r;
                  end
                  if (cls == CL_ANDL || ((cls == CL_ADD || cls == CL_ANDF) && !instr_r[9])) begin
                     wreg_nxt = res_r;
                  end else if (cls == CL_ADD || cls == CL_ANDF) begin
                     mem_we = 1'b1;
                     mem_wa = addr_r;
                     mem_wd = res_r;
                  end
                  if (cls == CL_BRC && status_r[FLG_C]) begin
                     // Counter still points at the branch word, so step past it before adding the offset
                     program_counter_nxt = program_counter_r + PC_W'(PC_STEP) + offset2;
                     taken_nxt = 1'b1;
                     state_nxt = ST_FLUSH;
                  end
               end
            endcase
         end
         // Extra cycle of a taken branch does nothing
         ST_FLUSH: begin
            q_nxt = q_r + 2'h1;
            if (q_r == Q_LAST) state_nxt = ST_IDLE;
         end
         default: begin
         end
      endcase
   end

   // State registers
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         state_r <= ST_IDLE;
         q_r <= 2'h0;
         instr_r <= 16'h0000;
         addr_r <= '0;
         opnd_r <= RST_BYTE;
         res_r <= RST_BYTE;
         flg_r <= RST_FLG;
         wreg_r <= RST_BYTE;
         status_r <= RST_FLG;
         bank_select_register_r <= '0;
         program_counter_r <= '0;
         index_r <= '0;
         maddr_r <= '0;
         ext_r <= 1'b0;
         taken_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rack_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         q_r <= q_nxt;
         instr_r <= instr_nxt;
         addr_r <= addr_nxt;
         opnd_r <= opnd_nxt;
         res_r <= res_nxt;
         flg_r <= flg_nxt;
         wreg_r <= wreg_nxt;
         status_r <= status_nxt;
         bank_select_register_r <= bank_select_register_nxt;
         program_counter_r <= program_counter_nxt;
         index_r <= index_nxt;
         maddr_r <= maddr_nxt;
         ext_r <= ext_nxt;
         taken_r <= taken_nxt;
         rdata_r <= rdata_nxt;
         rack_r <= rack_nxt;
      end
   end

   // Memory has no reset; contents are software's business
   always_ff @(posedge i_clk_sys) begin
      if (mem_we) mem[mem_wa] <= mem_wd;
   end

   // Checks
   sequence s_flush_then_idle;
      (state_r == ST_FLUSH) [*4] ##1 (state_r == ST_IDLE);
   endsequence

   sequence s_issue;
      wr_ok && i_avs_address == REG_INSTR && i_avs_writedata[15:8] != OPC_BR_CARRY;
   endsequence

   AST_ADD_SUM: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (state_r == ST_EXEC && q_r == 2'h2 && cls == CL_ADD) |=>
      res_r == 8'($past(wreg_r) + $past(opnd_r) + {7'h00, $past(status_r[FLG_C])}))
      else $error("add with carry result wrong");
   AST_ADD_DEST: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (state_r == ST_EXEC && q_r == Q_LAST && cls == CL_ADD && !instr_r[9]) |=>
      wreg_r == $past(res_r))
      else $error("add result not in working register");
   AST_BANKED: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (state_r == ST_EXEC && q_r == 2'h0 && instr_r[8]) |=>
      addr_r == {$past(bank_select_register_r), $past(instr_r[7:0])})
      else $error("banked address wrong");
   AST_INDEXED: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (state_r == ST_EXEC && q_r == 2'h0 && !instr_r[8] && ext_r && instr_r[7:0] <= IDX_LIMIT)
      |=> addr_r == $past(index_r) + {{BK_W{1'b0}}, $past(instr_r[7:0])})
      else $error("indexed address wrong");
   AST_AND_KEEPS: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (state_r == ST_EXEC && q_r == Q_LAST && cls == CL_ANDF) |=>
      status_r[FLG_C] == $past(status_r[FLG_C]) && status_r[FLG_OV] == $past(status_r[FLG_OV])
      && status_r[FLG_DC] == $past(status_r[FLG_DC]))
      else $error("and altered carry, digit carry or overflow");

   AST_BR_TARGET: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (state_r == ST_EXEC && q_r == Q_LAST && cls == CL_BRC) |=>
      program_counter_r == $past(program_counter_r) + PC_W'(PC_STEP)
      + ($past(status_r[FLG_C]) ? $past(offset2) : '0))
      else $error("branch target wrong");

   AST_BR_COST: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (state_r == ST_EXEC && q_r == Q_LAST && cls == CL_BRC && status_r[FLG_C]) |=>
      s_flush_then_idle)
      else $error("taken branch cost wrong");

   AST_BR_FLAGS: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (state_r != ST_IDLE && cls == CL_BRC) |=> $stable(status_r))
      else $error("branch changed status");

   AST_ONE_CYCLE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      s_issue |=>
      (state_r == ST_EXEC) [*4] ##1 (state_r == ST_IDLE))
      else $error("instruction did not finish in four phases");
endmodule // abx_core

`default_nettype wire

// ---- testbench/abx_prog_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Program memory seen by the fetch side, one 16-bit word per even address
module abx_prog_model #(
   parameter int AW = 21
) (
   // Fetch port
   input  wire logic [AW-1:0] i_fetch_addr,
   output logic      [15:0]   o_word
);
   logic [15:0] word_mem [0:255];

   // Only 256 words, so upper address bits alias; bench keeps programs small
   assign o_word = word_mem[i_fetch_addr[8:1]];

   // Filler is an unused opcode, so a stray fetch runs as a no-op
   initial begin
      for (int k = 0; k < 256; k++) begin
         word_mem[k] = 16'hFFFF;
      end
   end
endmodule // abx_prog_model

`default_nettype wire

// ---- testbench/abx_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module abx_core_tb
   import abx_pkg::*;
;
   // Bench signals
   logic        clk_sys;
   logic        resetn;
   logic [5:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        busy;
   logic [20:0] fetch_addr;
   logic [15:0] prog_word;
   logic [31:0] rdata;
   logic [31:0] pc_exp;
   logic [4:0]  st;
   int          n_mismatch;
   int          n_checks;
   int          busy_cnt;
   // Branch cases: carry, offset, start address
   logic        br_c  [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
   logic [7:0]  br_n  [4] = '{8'h05, 8'h05, 8'h80, 8'h7F};
   logic [15:0] br_pc [4] = '{16'h0100, 16'h0100, 16'h1000, 16'h1000};
   logic [5:0]  rst_a [6] = '{REG_CTRL, REG_WREG, REG_STATUS, REG_BANK, REG_PC, 6'h3C};

   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   abx_core #(.PC_W(21), .DMEM_AW(12)) i_abx_core (
      .i_clk_sys        (clk_sys),
      .i_resetn         (resetn),
      .i_avs_address    (avs_address),
      .i_avs_read       (avs_read),
      .i_avs_write      (avs_write),
      .i_avs_writedata  (avs_writedata),
      .i_avs_byteenable (4'hF),
      .o_avs_readdata   (avs_readdata),
      .o_avs_waitrequest(avs_waitrequest),
      .o_busy           (busy)
   );

   abx_prog_model #(.AW(21)) i_abx_prog_model (
      .i_fetch_addr(fetch_addr),
      .o_word      (prog_word)
   );

   // Busy length in clocks, cleared before each instruction while idle
   always @(posedge clk_sys) begin
      if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One Avalon transfer; a stalled write waits, only the watchdog bounds it
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= d;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk_sys);
      end
      rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic chk_reg(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdata, e);
   endtask

   task automatic mem_wr(input logic [11:0] a, input logic [7:0] v);
      bus(1'b1, REG_MADDR, {20'h0, a});
      bus(1'b1, REG_MDATA, {24'h0, v});
   endtask

   task automatic mem_chk(input logic [11:0] a, input logic [7:0] e);
      bus(1'b1, REG_MADDR, {20'h0, a});
      chk_reg(REG_MDATA, {24'h0, e});
   endtask

   // Place the word at the current counter, fetch it, hand it to the core
   task automatic issue(input logic [15:0] w);
      bus(1'b0, REG_PC, 32'h0);
      fetch_addr = rdata[20:0];
      i_abx_prog_model.word_mem[rdata[8:1]] = w;
      busy_cnt = 0;
      @(posedge clk_sys);
      bus(1'b1, REG_INSTR, {16'h0, prog_word});
   endtask

   task automatic run(input logic [15:0] w);
      issue(w);
      while (busy !== 1'b0) begin
         @(posedge clk_sys);
      end
   endtask

   function automatic logic [15:0] op_f(input logic [5:0] o, input logic d,
                                        input logic a, input logic [7:0] f);
      return {o, d, a, f};
   endfunction

   task automatic complete_run;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Watchdog, far beyond the few hundred clocks the tests need
   initial begin
      #200000;
      n_mismatch++;
      complete_run;
   end

   initial begin
      resetn = 1'b0;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      fetch_addr = 21'h0;
      n_mismatch = 0;
      n_checks = 0;
      busy_cnt = 0;
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      // Reset values, unmapped place ignores writes and reads zero
      bus(1'b1, 6'h3C, 32'hFFFFFFFF);
      foreach (rst_a[k]) chk_reg(rst_a[k], 32'h0);
      // Add with carry into wreg, access bank
      bus(1'b1, REG_STATUS, 32'h1);
      bus(1'b1, REG_WREG, 32'h4D);
      mem_wr(12'h010, 8'h02);
      run(op_f(OPC_ADD_CARRY, 1'b0, 1'b0, 8'h10));
      chk_reg(REG_WREG, 32'h50);
      chk_reg(REG_STATUS, 32'h02);
      mem_chk(12'h010, 8'h02);
      // Add with carry into file through bank 3; overflow and carry out
      bus(1'b1, REG_BANK, 32'h3);
      bus(1'b1, REG_STATUS, 32'h0);
      bus(1'b1, REG_WREG, 32'h80);
      mem_wr(12'h340, 8'h80);
      mem_wr(12'h040, 8'h11);
      run(op_f(OPC_ADD_CARRY, 1'b1, 1'b1, 8'h40));
      chk_reg(REG_WREG, 32'h80);
      chk_reg(REG_STATUS, 32'h0D);
      mem_chk(12'h340, 8'h00);
      mem_chk(12'h040, 8'h11);
      // AND into file, high access half; C, DC, OV must survive
      bus(1'b1, REG_STATUS, 32'h0B);
      bus(1'b1, REG_WREG, 32'h17);
      mem_wr(12'hF70, 8'hC2);
      run(op_f(OPC_AND_FILE, 1'b1, 1'b0, 8'h70));
      chk_reg(REG_WREG, 32'h17);
      chk_reg(REG_STATUS, 32'h0B);
      mem_chk(12'hF70, 8'h02);
      // Indexed mode at the 5Fh boundary and just past it
      bus(1'b1, REG_CTRL, 32'h1);
      bus(1'b1, REG_INDEX, 32'h200);
      bus(1'b1, REG_STATUS, 32'h0);
      bus(1'b1, REG_WREG, 32'hF0);
      mem_wr(12'h205, 8'h0F);
      mem_wr(12'h05F, 8'hFF);
      mem_wr(12'h25F, 8'h0F);
      mem_wr(12'hF60, 8'h3C);
      run(op_f(OPC_AND_FILE, 1'b0, 1'b0, 8'h5F));
      chk_reg(REG_WREG, 32'h00);
      chk_reg(REG_STATUS, 32'h04);
      bus(1'b1, REG_WREG, 32'hF0);
      run(op_f(OPC_AND_FILE, 1'b0, 1'b0, 8'h60));
      chk_reg(REG_WREG, 32'h30);
      bus(1'b1, REG_CTRL, 32'h0);
      // AND literal; one instruction cycle is the reference length
      bus(1'b1, REG_STATUS, 32'h09);
      bus(1'b1, REG_WREG, 32'hA3);
      run({OPC_AND_LIT, 8'h5F});
      chk(busy_cnt, 32'd4);
      chk_reg(REG_WREG, 32'h03);
      chk_reg(REG_STATUS, 32'h09);
      bus(1'b1, REG_WREG, 32'h80);
      run({OPC_AND_LIT, 8'hFF});
      chk_reg(REG_STATUS, 32'h19);
      // Branch on carry: not taken, taken, both offset extremes
      for (int k = 0; k < 4; k++) begin
         st = br_c[k] ? 5'h1F : 5'h1E;
         bus(1'b1, REG_STATUS, {27'h0, st});
         bus(1'b1, REG_PC, {16'h0, br_pc[k]});
         run({OPC_BR_CARRY, br_n[k]});
         pc_exp = {16'h0, br_pc[k]} + 32'd2;
         if (br_c[k]) pc_exp = pc_exp + {{23{br_n[k][7]}}, br_n[k], 1'b0};
         chk_reg(REG_PC, pc_exp);
         chk_reg(REG_STATUS, {27'h0, st});
         chk_reg(REG_INFO, {30'h0, br_c[k], 1'b0});
         chk(busy_cnt, br_c[k] ? 32'd8 : 32'd4);
      end
      // Write issued mid-branch is held off, not lost
      bus(1'b1, REG_STATUS, 32'h1);
      bus(1'b1, REG_PC, 32'h100);
      issue({OPC_BR_CARRY, 8'h05});
      bus(1'b1, REG_WREG, 32'h5A);
      chk(busy_cnt, 32'd8);
      chk_reg(REG_WREG, 32'h5A);
      complete_run;
   end
endmodule // abx_core_tb

`default_nettype wire
